/* File: ecc_cap_tx.sv */
`include "ecc_regs.svh"

module ecc_cap_tx (
    input  wire logic       clk_sys,    // encoder clock
    input  wire logic       rst_b,      // async reset, active low
    input  wire logic       load,       // copy pair into transmitter
    input  wire logic       autoParity, // overwrite msb with odd parity
    input  wire logic [7:0] byteFirst,  // first loaded byte
    input  wire logic [7:0] byteSecond, // second loaded byte
    output logic      [7:0] txFirst,    // first byte being transmitted
    output logic      [7:0] txSecond    // second byte being transmitted
);

    logic [7:0] rawByte [2];
    logic [7:0] outByte [2];

    assign rawByte[0] = byteFirst;
    assign rawByte[1] = byteSecond;

    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : gByte
            // odd parity over the seven data bits sets the eighth
            wire parityBit = ~(^rawByte[gi][6:0]);
            assign outByte[gi] = autoParity ? {parityBit, rawByte[gi][6:0]}
                                            : rawByte[gi];
        end
    endgenerate

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            txFirst  <= `ECC_CAP_BYTE_RST;
            txSecond <= `ECC_CAP_BYTE_RST;
        end else if (load) begin
            txFirst  <= outByte[0];
            txSecond <= outByte[1];
        end
    end

    default clocking cbTx @(posedge clk_sys); endclocking
    default disable iff (!rst_b);

    AST_TX_PARITY_ODD: assert property (load && autoParity |=>
        (^txFirst) && (^txSecond))
        else $error("caption byte parity not odd");
    AST_TX_RAW_PASS: assert property (load && !autoParity |=>
        txFirst == $past(byteFirst) && txSecond == $past(byteSecond))
        else $error("caption bytes altered without auto parity");

endmodule : ecc_cap_tx

/* File: ecc_ctrl.sv */
`include "ecc_regs.svh"

module ecc_ctrl (
    input  wire logic        clk_sys,        // 27 MHz encoder clock
    input  wire logic        rst_b,          // async reset, active low
    input  wire logic        serial_select_n,// low = serial control mode
    input  wire logic [7:0]  regAddr,        // register address
    input  wire logic        regWr,          // write strobe, one cycle
    input  wire logic        regRd,          // read strobe, level while reading
    input  wire logic [7:0]  regWrData,      // write data
    output logic      [7:0]  regRdData,      // read data, one cycle later
    input  wire logic [7:0]  pinIn,          // data pin levels
    output logic      [7:0]  pinOut,         // data pin drive values
    output logic      [7:0]  pinOe_b,        // data pin enables, low drives
    input  wire logic        videoNtscM,     // NTSC or PAL-M format
    input  wire logic [9:0]  frameLine,      // line number in frame
    input  wire logic [9:0]  fieldLine,      // line number in field
    input  wire logic        oddField,       // high in odd field
    input  wire logic        hsyncFall,      // horizontal sync falling edge pulse
    input  wire logic        vsyncRaw_b,     // vertical sync from timing, low active
    input  wire logic        pixelValidRaw,  // pixel data valid from timing
    input  wire logic        blueSampleRaw,  // Cb sample marker from timing
    input  wire logic        vbiLine,        // current line is vertical interval
    input  wire logic        burstWindow,    // burst window from timing
    input  wire logic        compSyncRaw_b,  // composite sync, low on tips
    output logic             pedestalEarly,  // add pedestal on this early line
    output logic             vsyncPin,       // vertical sync pin value
    output logic             blankSelPin,    // shared blanking/marker pin value
    output logic             vbiBlank,       // blank current vertical line
    output logic             vbiEncode,      // encode pixels on vertical line
    output ecc_pkg::ecc_sync_delay_t syncDelay, // sync edge alignment
    output logic             capLineData,    // caption line carries data
    output logic             capLineNull,    // caption line carries null bytes
    output logic      [7:0]  capTxFirst,     // first transmitted caption byte
    output logic      [7:0]  capTxSecond     // second transmitted caption byte
);

    logic [7:0] genCtrl;
    logic [7:0] capFirst;
    logic [7:0] capSecond;
    logic [7:0] capCtrl;
    logic [3:0] portOut;
    ecc_pkg::ecc_cap_state_t capState;
    ecc_pkg::ecc_cap_state_t next_capState;

    // address decode
    wire serialMode = !serial_select_n;
    wire selPort    = regAddr == `ECC_ADDR_PORT;
    wire selGen     = regAddr == `ECC_ADDR_GENERAL;
    wire selFirst   = regAddr == `ECC_ADDR_CAP_FIRST;
    wire selSecond  = regAddr == `ECC_ADDR_CAP_SECND;
    wire selCtrl    = regAddr == `ECC_ADDR_CAP_CTRL;
    wire wrGen      = regWr && selGen;
    wire wrFirst    = regWr && selFirst;
    wire wrSecond   = regWr && selSecond;
    wire wrCtrl     = regWr && selCtrl;
    wire wrPort     = regWr && selPort;

    // general control fields
    wire earlyPedEn  = genCtrl[`ECC_GEN_EARLY_PED];
    wire vertPinSel  = genCtrl[`ECC_GEN_VPIN_SEL];
    wire blueMarkSel = genCtrl[`ECC_GEN_BLUE_MARK];
    wire vbiEnBit    = genCtrl[`ECC_GEN_VBI_DATA];

    // caption control fields
    wire       capEn     = capCtrl[`ECC_CAP_EN];
    wire       capRts    = capCtrl[`ECC_CAP_RTS];
    wire       capPar    = capCtrl[`ECC_CAP_PAR];
    wire       capFldSel = capCtrl[`ECC_CAP_FLD];
    wire [3:0] capLine   = capCtrl[`ECC_CAP_LINE_MSB:`ECC_CAP_LINE_LSB];

    // caption line timing: trigger on the hsync edge that opens the target line
    wire [9:0] capTarget  = `ECC_CAP_LINE_OFFSET + {6'h00, capLine};
    wire [9:0] nextLine   = fieldLine + 10'h001;
    wire       capFieldOk = capFldSel ? !oddField : oddField;
    wire       capTrigger = hsyncFall && capEn && capFieldOk
                            && (nextLine == capTarget);
    wire       capLoad    = capTrigger && capRts;
    // a host write that sets the request in the same cycle wins over the clear
    wire       rtsSetWr   = wrCtrl && regWrData[`ECC_CAP_RTS];
    wire       next_rts   = rtsSetWr ? 1'b1 : (capLoad ? 1'b0 :
                            (wrCtrl ? 1'b0 : capRts));

    // early pedestal line match
    wire pedLine = (frameLine == `ECC_PED_LINE_A) || (frameLine == `ECC_PED_LINE_B)
                || (frameLine == `ECC_PED_LINE_C) || (frameLine == `ECC_PED_LINE_D)
                || (frameLine == `ECC_PED_LINE_E);

    // port register view; inputs only exist in serial mode
    wire [1:0] gpIn      = serialMode ? pinIn[7:6] : 2'h0;
    wire [7:0] portView  = {gpIn, portOut, burstWindow, compSyncRaw_b};

    wire [7:0] rdMux = selPort   ? portView :
                       selGen    ? {genCtrl[7], 1'b0, genCtrl[5:3], 1'b0, genCtrl[1:0]} :
                       selFirst  ? capFirst :
                       selSecond ? capSecond :
                       selCtrl   ? capCtrl : 8'h00;

    // pin drive: serial mode fixes the port function, parallel mode drives read data
    wire [7:0] serialPins   = {2'h0, portOut, burstWindow, compSyncRaw_b};
    wire [7:0] next_pinOut  = serialMode ? serialPins : rdMux;
    wire [7:0] next_pinOe_b = serialMode ? 8'hC0 : (regRd ? 8'h00 : 8'hFF);

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            genCtrl <= `ECC_GEN_RST;
        end else if (wrGen) begin
            genCtrl <= regWrData;
        end
    end

    // host side of the hand-off: bytes may be loaded at any time before the request
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            capFirst  <= `ECC_CAP_BYTE_RST;
            capSecond <= `ECC_CAP_BYTE_RST;
        end else begin
            if (wrFirst) begin
                capFirst <= regWrData;
            end
            if (wrSecond) begin
                capSecond <= regWrData;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            capCtrl <= `ECC_CAP_CTRL_RST;
        end else begin
            capCtrl[`ECC_CAP_RTS] <= next_rts;
            if (wrCtrl) begin
                capCtrl[7] <= regWrData[7];
                capCtrl[5:0] <= regWrData[5:0];
            end
        end
    end

    // writes to the input bits are dropped; only bits 5-2 store
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            portOut <= `ECC_PORT_OUT_RST;
        end else if (wrPort) begin
            portOut <= regWrData[`ECC_PORT_OUT_MSB:`ECC_PORT_OUT_LSB];
        end
    end

    // read data sampled when the read executes, so gp inputs are a snapshot
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            regRdData <= 8'h00;
            pinOut    <= 8'h00;
            pinOe_b   <= 8'hFF;
        end else begin
            regRdData <= regRd ? rdMux : 8'h00;
            pinOut    <= next_pinOut;
            pinOe_b   <= next_pinOe_b;
        end
    end

    // caption line state lasts until the hsync edge that ends the line
    always_comb begin
        next_capState = capState;
        case (capState)
            ecc_pkg::ECC_CAP_IDLE: begin
                if (capTrigger) begin
                    next_capState = capRts ? ecc_pkg::ECC_CAP_DATA
                                           : ecc_pkg::ECC_CAP_NULL;
                end
            end
            ecc_pkg::ECC_CAP_DATA,
            ecc_pkg::ECC_CAP_NULL: begin
                if (hsyncFall) begin
                    next_capState = ecc_pkg::ECC_CAP_IDLE;
                end
            end
            default: begin
                next_capState = ecc_pkg::ECC_CAP_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            capState <= ecc_pkg::ECC_CAP_IDLE;
        end else begin
            capState <= next_capState;
        end
    end

    // pin functions and video controls, registered for clean pin timing
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            pedestalEarly <= 1'b0;
            vsyncPin      <= 1'b1;
            blankSelPin   <= 1'b0;
            vbiBlank      <= 1'b0;
            vbiEncode     <= 1'b0;
        end else begin
            pedestalEarly <= earlyPedEn && videoNtscM && pedLine;
            vsyncPin      <= vertPinSel ? !oddField : vsyncRaw_b;
            blankSelPin   <= blueMarkSel ? blueSampleRaw : pixelValidRaw;
            vbiBlank      <= vbiLine && !vbiEnBit;
            vbiEncode     <= vbiLine && vbiEnBit;
        end
    end

    assign syncDelay   = ecc_pkg::ecc_sync_delay_t'(
                         genCtrl[`ECC_GEN_SYNC_DLY_MSB:`ECC_GEN_SYNC_DLY_LSB]);
    assign capLineData = capState == ecc_pkg::ECC_CAP_DATA;
    assign capLineNull = capState == ecc_pkg::ECC_CAP_NULL;

    ecc_cap_tx ecc_cap_tx_i (
        .clk_sys    (clk_sys),
        .rst_b      (rst_b),
        .load       (capTrigger),
        .autoParity (capPar),
        .byteFirst  (capRts ? capFirst  : `ECC_CAP_NULL_BYTE),
        .byteSecond (capRts ? capSecond : `ECC_CAP_NULL_BYTE),
        .txFirst    (capTxFirst),
        .txSecond   (capTxSecond)
    );

    default clocking cbCtrl @(posedge clk_sys); endclocking
    default disable iff (!rst_b);

    sequence seqCapReq;
        capTrigger && capRts && !rtsSetWr && capState == ecc_pkg::ECC_CAP_IDLE;
    endsequence
    sequence seqCapNoReq;
        capTrigger && !capRts && capState == ecc_pkg::ECC_CAP_IDLE;
    endsequence

    AST_CAP_RTS_CLEAR: assert property (seqCapReq |=> !capRts && capLineData)
        else $error("send request not cleared at caption load");
    AST_CAP_NULL_LINE: assert property (seqCapNoReq |=> capLineNull
        && capTxFirst == ($past(capPar) ? 8'h80 : 8'h00))
        else $error("null bytes not sent without request");
    AST_CAP_FIELD: assert property (capTrigger |-> (capFldSel != oddField))
        else $error("caption on wrong field");
    AST_VSYNC_FIELD: assert property (vertPinSel && !wrGen |=>
        vsyncPin == !$past(oddField))
        else $error("field id wrong on vertical pin");
    AST_BLANK_SEL: assert property (!blueMarkSel && !wrGen |=>
        blankSelPin == $past(pixelValidRaw))
        else $error("blanking pin function wrong");
    AST_PED_EARLY: assert property (pedestalEarly |->
        $past(earlyPedEn) && $past(videoNtscM))
        else $error("early pedestal without enable");
    // the serial gp pin check skips the first edge after reset, when the flops still show reset values
    AST_GP_SERIAL_OUT: assert property ((rst_b && serialMode && !wrPort) [*2] |->
        pinOut[5:2] == portOut && pinOe_b[5:0] == 6'h00)
        else $error("serial gp outputs not driven");
    AST_GP_PAR_IDLE: assert property (!serialMode && !regRd |=> pinOe_b == 8'hFF)
        else $error("parallel pins driven outside read");
    AST_GP_IN_SAMPLE: assert property (regRd && selPort && serialMode |=>
        regRdData[7:6] == $past(pinIn[7:6]))
        else $error("gp input not sampled at read");
    AST_GP_IN_PARALLEL: assert property (regRd && selPort && !serialMode |=>
        regRdData[7:6] == 2'h0)
        else $error("gp input visible in parallel mode");
    AST_GP_OUT_READBACK: assert property (regRd && selPort |=>
        regRdData[`ECC_PORT_OUT_MSB:`ECC_PORT_OUT_LSB] == $past(portOut))
        else $error("gp output bits not read back");
    AST_GP_PAR_READ: assert property (!serialMode && regRd |=>
        pinOe_b == 8'h00 && pinOut == regRdData)
        else $error("parallel read not driven on pins");
    AST_SYNC_PINS: assert property (rst_b && serialMode |=>
        pinOut[1:0] == {$past(burstWindow), $past(compSyncRaw_b)} && pinOe_b[1:0] == 2'h0)
        else $error("serial sync pins not driven");
    AST_VBI_LINES: assert property (rst_b && vbiLine |=>
        vbiEncode == $past(vbiEnBit) && vbiBlank == !$past(vbiEnBit))
        else $error("vertical interval line handling wrong");
    AST_PED_OFF: assert property (!(pedLine && videoNtscM) |=>
        !pedestalEarly)
        else $error("pedestal on a line outside the early set");
    AST_RTS_SET_WINS: assert property (rtsSetWr |=>
        capRts)
        else $error("host send request lost");

endmodule : ecc_ctrl

/* File: ecc_host_model.sv */
module ecc_host_model (
    input  wire logic       clk_sys,   // encoder clock
    output logic      [7:0] regAddr,   // register address
    output logic            regWr,     // one-cycle write pulse
    output logic            regRd,     // read level
    output logic      [7:0] regWrData, // write data
    input  wire logic [7:0] regRdData  // read data, one cycle after sampling
);
    timeunit 1ns;
    timeprecision 100ps;

    initial begin
        regAddr = 8'h00;
        regWr = 1'b0;
        regRd = 1'b0;
        regWrData = 8'h00;
    end

    // released lines show the inverse so a stale value never passes as current
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        regAddr <= a;
        regWrData <= d;
        regWr <= 1'b1;
        @(posedge clk_sys);
        regWr <= 1'b0;
        regAddr <= ~a;
        regWrData <= ~d;
    endtask : wr

    // read held for n edges keeps parallel outputs steady
    task automatic rd(input logic [7:0] a, input int n, output logic [7:0] d);
        @(posedge clk_sys);
        regAddr <= a;
        regRd <= 1'b1;
        repeat (n) @(posedge clk_sys);
        regRd <= 1'b0;
        regAddr <= ~a;
        #1 d = regRdData;
    endtask : rd
endmodule : ecc_host_model

/* File: ecc_pkg.sv */
package ecc_pkg;

    typedef enum logic [1:0] {
        ECC_CAP_IDLE = 2'b00,
        ECC_CAP_DATA = 2'b01,
        ECC_CAP_NULL = 2'b10
    } ecc_cap_state_t;

    typedef enum logic [1:0] {
        ECC_SYNC_Y735  = 2'b00,
        ECC_SYNC_CB736 = 2'b01,
        ECC_SYNC_Y736  = 2'b10,
        ECC_SYNC_CR736 = 2'b11
    } ecc_sync_delay_t;

endpackage : ecc_pkg

/* File: ecc_regs.svh */
`ifndef ECC_REGS_SVH
`define ECC_REGS_SVH

// register offsets
`define ECC_ADDR_PORT      8'h0E
`define ECC_ADDR_GENERAL   8'h0F
`define ECC_ADDR_CAP_FIRST 8'h20
`define ECC_ADDR_CAP_SECND 8'h21
`define ECC_ADDR_CAP_CTRL  8'h22

// general control fields
`define ECC_GEN_EARLY_PED    7
`define ECC_GEN_VPIN_SEL     5
`define ECC_GEN_BLUE_MARK    4
`define ECC_GEN_VBI_DATA     3
`define ECC_GEN_SYNC_DLY_MSB 1
`define ECC_GEN_SYNC_DLY_LSB 0

// caption control fields
`define ECC_CAP_EN         7
`define ECC_CAP_RTS        6
`define ECC_CAP_PAR        5
`define ECC_CAP_FLD        4
`define ECC_CAP_LINE_MSB   3
`define ECC_CAP_LINE_LSB   0

// port register fields
`define ECC_PORT_IN_MSB    7
`define ECC_PORT_IN_LSB    6
`define ECC_PORT_OUT_MSB   5
`define ECC_PORT_OUT_LSB   2
`define ECC_PORT_BURST     1
`define ECC_PORT_COMP_SYNC 0

// reset values
`define ECC_GEN_RST        8'h00
`define ECC_CAP_BYTE_RST   8'h00
`define ECC_CAP_CTRL_RST   8'h00
`define ECC_PORT_OUT_RST   4'h0

// caption line placement and content
`define ECC_CAP_LINE_OFFSET 10'h00A
`define ECC_CAP_NULL_BYTE   8'h00

// early pedestal lines
`define ECC_PED_LINE_A     10'h015
`define ECC_PED_LINE_B     10'h016
`define ECC_PED_LINE_C     10'h11B
`define ECC_PED_LINE_D     10'h11C
`define ECC_PED_LINE_E     10'h11D

`endif

/* File: tb_ecc_ctrl.sv */
`include "ecc_regs.svh"

module tb_ecc_ctrl;
    timeunit 1ns;
    timeprecision 100ps;

    logic       clk_sys, rst_b, serial_select_n, regWr, regRd;
    logic [7:0] regAddr, regWrData, regRdData, pinIn, pinOut, pinOe_b;
    logic       videoNtscM, oddField, hsyncFall, vsyncRaw_b, pixelValidRaw, blueSampleRaw;
    logic       vbiLine, burstWindow, compSyncRaw_b, pedestalEarly, vsyncPin, blankSelPin;
    logic       vbiBlank, vbiEncode, capLineData, capLineNull;
    logic [9:0] frameLine, fieldLine;
    logic [7:0] capTxFirst, capTxSecond;
    ecc_pkg::ecc_sync_delay_t syncDelay;
    int         nFail, nCompared, cycles;

    ecc_ctrl ecc_ctrl_i (.clk_sys, .rst_b, .serial_select_n, .regAddr, .regWr, .regRd,
        .regWrData, .regRdData, .pinIn, .pinOut, .pinOe_b, .videoNtscM, .frameLine,
        .fieldLine, .oddField, .hsyncFall, .vsyncRaw_b, .pixelValidRaw, .blueSampleRaw,
        .vbiLine, .burstWindow, .compSyncRaw_b, .pedestalEarly, .vsyncPin, .blankSelPin,
        .vbiBlank, .vbiEncode, .syncDelay, .capLineData, .capLineNull, .capTxFirst,
        .capTxSecond);

    ecc_host_model ecc_host_model_i (.clk_sys, .regAddr, .regWr, .regRd, .regWrData,
        .regRdData);

    initial begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end

    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        nCompared++;
        if (seen !== exp) begin
            nFail++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic print_verdict;
        $display("compared %0d failed %0d", nCompared, nFail);
        if (nFail == 0 && nCompared > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : print_verdict

    // hangs are cut short well above the hundred or so cycles the run needs
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            nFail++;
            print_verdict();
        end
    end

    task automatic pulse_hsync;
        @(posedge clk_sys);
        hsyncFall <= 1'b1;
        @(posedge clk_sys);
        hsyncFall <= 1'b0;
        #1;
    endtask : pulse_hsync

    task automatic t_reset_map;
        logic [7:0] d;
        logic [7:0] adr [5];
        adr = '{`ECC_ADDR_GENERAL, `ECC_ADDR_CAP_FIRST, `ECC_ADDR_CAP_SECND, `ECC_ADDR_CAP_CTRL,
                8'h30};
        check("vsyncPin", {7'h00, vsyncPin}, 8'h01);
        ecc_host_model_i.wr(8'h30, 8'hFF);
        foreach (adr[i]) begin
            ecc_host_model_i.rd(adr[i], 1, d);
            check("reset value", d, 8'h00);
        end
    endtask : t_reset_map

    task automatic t_general;
        logic [7:0] d;
        ecc_host_model_i.wr(`ECC_ADDR_GENERAL, 8'hFF);
        ecc_host_model_i.rd(`ECC_ADDR_GENERAL, 1, d);
        check("general", d, 8'hBB);
        @(posedge clk_sys);
        oddField <= 1'b1;
        blueSampleRaw <= 1'b1;
        vbiLine <= 1'b1;
        frameLine <= 10'd21;
        repeat (2) @(posedge clk_sys);
        #1 check("vsyncPin", {7'h00, vsyncPin}, 8'h00);
        check("blankSelPin", {7'h00, blankSelPin}, 8'h01);
        check("vbi", {6'h00, vbiEncode, vbiBlank}, 8'h02);
        check("pedestal", {7'h00, pedestalEarly}, 8'h01);
        @(posedge clk_sys);
        oddField <= 1'b0;
        frameLine <= 10'd23;
        repeat (2) @(posedge clk_sys);
        #1 check("vsyncPin", {7'h00, vsyncPin}, 8'h01);
        check("pedestal", {7'h00, pedestalEarly}, 8'h00);
        @(posedge clk_sys);
        vsyncRaw_b <= 1'b0;
        pixelValidRaw <= 1'b1;
        frameLine <= 10'd285;
        ecc_host_model_i.wr(`ECC_ADDR_GENERAL, 8'h00);
        repeat (2) @(posedge clk_sys);
        #1 check("vsyncPin", {7'h00, vsyncPin}, 8'h00);
        check("blankSelPin", {7'h00, blankSelPin}, 8'h01);
        check("vbi", {6'h00, vbiEncode, vbiBlank}, 8'h01);
        check("pedestal", {7'h00, pedestalEarly}, 8'h00);
        for (int i = 0; i < 4; i++) begin
            ecc_host_model_i.wr(`ECC_ADDR_GENERAL, 8'(i));
            #1 check("syncDelay", {6'h00, syncDelay}, 8'(i));
        end
    endtask : t_general

    task automatic t_caption;
        logic [7:0] d;
        @(posedge clk_sys);
        fieldLine <= 10'd14;
        ecc_host_model_i.wr(`ECC_ADDR_CAP_FIRST, 8'h81);
        ecc_host_model_i.wr(`ECC_ADDR_CAP_SECND, 8'h03);
        ecc_host_model_i.wr(`ECC_ADDR_CAP_CTRL, 8'hE5);
        pulse_hsync();
        check("wrong field", {7'h00, capLineData}, 8'h00);
        @(posedge clk_sys);
        oddField <= 1'b1;
        pulse_hsync();
        check("data line", {6'h00, capLineNull, capLineData}, 8'h01);
        check("tx first", capTxFirst, 8'h01);
        check("tx second", capTxSecond, 8'h83);
        ecc_host_model_i.rd(`ECC_ADDR_CAP_CTRL, 1, d);
        check("request cleared", d, 8'hA5);
        @(posedge clk_sys);
        fieldLine <= 10'd15;
        pulse_hsync();
        @(posedge clk_sys);
        fieldLine <= 10'd14;
        repeat (2) @(posedge clk_sys);
        pulse_hsync();
        check("null line", {6'h00, capLineNull, capLineData}, 8'h02);
        check("null parity", capTxFirst, 8'h80);
        ecc_host_model_i.wr(`ECC_ADDR_CAP_FIRST, 8'h81);
        ecc_host_model_i.wr(`ECC_ADDR_CAP_SECND, 8'h7F);
        ecc_host_model_i.wr(`ECC_ADDR_CAP_CTRL, 8'hD6);
        oddField <= 1'b0;
        pulse_hsync();
        check("line offset", {7'h00, capLineData}, 8'h00);
        @(posedge clk_sys);
        fieldLine <= 10'd15;
        repeat (2) @(posedge clk_sys);
        pulse_hsync();
        check("even field", {7'h00, capLineData}, 8'h01);
        check("raw first", capTxFirst, 8'h81);
        check("raw second", capTxSecond, 8'h7F);
    endtask : t_caption

    task automatic t_port;
        logic [7:0] d;
        @(posedge clk_sys);
        pinIn <= 8'h80;
        burstWindow <= 1'b1;
        compSyncRaw_b <= 1'b0;
        ecc_host_model_i.wr(`ECC_ADDR_PORT, 8'hFF);
        ecc_host_model_i.rd(`ECC_ADDR_PORT, 1, d);
        check("port read", d, 8'hBE);
        check("serial oe", pinOe_b, 8'hC0);
        check("serial pins", {2'b00, pinOut[5:0]}, 8'h3E);
        @(posedge clk_sys);
        pinIn <= 8'h40;
        burstWindow <= 1'b0;
        compSyncRaw_b <= 1'b1;
        ecc_host_model_i.wr(`ECC_ADDR_PORT, 8'h24);
        ecc_host_model_i.rd(`ECC_ADDR_PORT, 1, d);
        check("port read", d, 8'h65);
        check("serial pins", {2'b00, pinOut[5:0]}, 8'h25);
        @(posedge clk_sys);
        serial_select_n <= 1'b1;
        pinIn <= 8'hC0;
        repeat (2) @(posedge clk_sys);
        #1 check("parallel idle oe", pinOe_b, 8'hFF);
        ecc_host_model_i.rd(`ECC_ADDR_PORT, 4, d);
        check("parallel read", d, 8'h25);
        check("parallel oe", pinOe_b, 8'h00);
        check("parallel pins", pinOut, 8'h25);
        @(posedge clk_sys);
        #1 check("parallel oe off", pinOe_b, 8'hFF);
    endtask : t_port

    initial begin
        {nFail, nCompared, cycles} = '0;
        {rst_b, serial_select_n, videoNtscM, oddField, hsyncFall} = '0;
        {pixelValidRaw, blueSampleRaw, vbiLine, burstWindow} = '0;
        {vsyncRaw_b, compSyncRaw_b} = 2'b11;
        pinIn = 8'h00;
        frameLine = 10'h000;
        fieldLine = 10'h000;
        videoNtscM = 1'b1;
        repeat (3) @(posedge clk_sys);
        rst_b <= 1'b1;
        t_reset_map();
        t_general();
        t_caption();
        t_port();
        print_verdict();
    end
endmodule : tb_ecc_ctrl
